// ---- rtl/pcm_top.v ----
`timescale 1ns/1ps
`include "pcm_map.vh"

module pcm_top #(
  parameter NUM_MOD = 6
) (
  input wire clk,
  input wire rst,
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_wdata,
  input wire sfr_wr,
  input wire sfr_rd,
  output reg [7:0] sfr_rdata,
  input wire [15:0] main_counter,
  input wire count_tick,
  input wire [5:0] module_input_pin,
  input wire [5:0] flag_clear,
  output reg [5:0] compare_event_flag,
  output wire [5:0] module_output_pin,
  output reg cycle_wrap_flag,
  output reg pca_irq
);

  // ----------------------------------------------------------------
  // Address decoding
  // ----------------------------------------------------------------
  function [3:0] mode_dec;
    input [7:0] a;
    begin
      case (a)
        `PCM_ADDR_MODE6: mode_dec = 4'h8;
        `PCM_ADDR_MODE7: mode_dec = 4'h9;
        `PCM_ADDR_MODE8: mode_dec = 4'hA;
        `PCM_ADDR_MODE9: mode_dec = 4'hB;
        `PCM_ADDR_MODE10: mode_dec = 4'hC;
        `PCM_ADDR_MODE11: mode_dec = 4'hD;
        default: mode_dec = 4'h0;
      endcase
    end
  endfunction

  function [3:0] lo_dec;
    input [7:0] a;
    begin
      case (a)
        `PCM_ADDR_LO6: lo_dec = 4'h8;
        `PCM_ADDR_LO7: lo_dec = 4'h9;
        `PCM_ADDR_LO8: lo_dec = 4'hA;
        `PCM_ADDR_LO9: lo_dec = 4'hB;
        `PCM_ADDR_LO10: lo_dec = 4'hC;
        `PCM_ADDR_LO11: lo_dec = 4'hD;
        default: lo_dec = 4'h0;
      endcase
    end
  endfunction

  function [3:0] hi_dec;
    input [7:0] a;
    begin
      case (a)
        `PCM_ADDR_HI6: hi_dec = 4'h8;
        `PCM_ADDR_HI7: hi_dec = 4'h9;
        `PCM_ADDR_HI8: hi_dec = 4'hA;
        `PCM_ADDR_HI9: hi_dec = 4'hB;
        `PCM_ADDR_HI10: hi_dec = 4'hC;
        `PCM_ADDR_HI11: hi_dec = 4'hD;
        default: hi_dec = 4'h0;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  reg reload_bank_select;
  reg cycle_wrap_irq_en;
  reg [1:0] cycle_length_sel;
  reg cycle_wrap_flag_next;
  reg [7:0] mode_reg [0:NUM_MOD-1];
  reg [7:0] rdata_next;
  wire [15:0] cmp_value [0:NUM_MOD-1];
  wire [15:0] reload_value [0:NUM_MOD-1];
  wire [NUM_MOD-1:0] event_set;
  wire [NUM_MOD-1:0] irq_en;
  wire [3:0] mode_hit = mode_dec(sfr_addr);
  wire [3:0] lo_hit = lo_dec(sfr_addr);
  wire [3:0] hi_hit = hi_dec(sfr_addr);
  wire cfg_wr = sfr_wr & (sfr_addr == `PCM_ADDR_CFG);
  wire [15:0] len_mask;
  wire wrap_evt;
  wire ovf16_evt;
  wire [7:0] cfg_read;

  // Unused bits 4:2 are never stored
  assign cfg_read = {reload_bank_select, cycle_wrap_irq_en, cycle_wrap_flag,
                     3'h0, cycle_length_sel};

  // ----------------------------------------------------------------
  // Cycle wrap detection
  // ----------------------------------------------------------------
  pcm_wrap_det u_wrap (
    .main_counter(main_counter),
    .count_tick(count_tick),
    .cycle_length_sel(cycle_length_sel),
    .len_mask(len_mask),
    .wrap_evt(wrap_evt),
    .ovf16_evt(ovf16_evt)
  );

  // ----------------------------------------------------------------
  // Configuration register
  // ----------------------------------------------------------------
  always @* begin
    cycle_wrap_flag_next = cycle_wrap_flag;
    if (cfg_wr) begin
      cycle_wrap_flag_next = sfr_wdata[`PCM_CFG_WRAP_FLAG];
    end
    // Hardware set wins over a clearing write in the same cycle
    if (wrap_evt) begin
      cycle_wrap_flag_next = 1'b1;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      reload_bank_select <= 1'b0;
      cycle_wrap_irq_en <= 1'b0;
      cycle_length_sel <= `PCM_LEN_8;
      cycle_wrap_flag <= 1'b0;
    end else begin
      cycle_wrap_flag <= cycle_wrap_flag_next;
      if (cfg_wr) begin
        reload_bank_select <= sfr_wdata[`PCM_CFG_BANK];
        cycle_wrap_irq_en <= sfr_wdata[`PCM_CFG_WRAP_IE];
        cycle_length_sel <= sfr_wdata[`PCM_CFG_LEN_HI:`PCM_CFG_LEN_LO];
      end
    end
  end

  // ----------------------------------------------------------------
  // Per-module mode registers, flags and channels
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_MOD; g = g + 1) begin : gen_mod
      localparam integer SEL_I = 8 + g;
      localparam [3:0] SEL = SEL_I[3:0];
      wire wr_mode = sfr_wr & (mode_hit == SEL);
      wire wr_lo = sfr_wr & (lo_hit == SEL);
      wire wr_hi = sfr_wr & (hi_hit == SEL);

      always @(posedge clk or posedge rst) begin
        if (rst) begin
          mode_reg[g] <= `PCM_RST_BYTE;
        end else if (wr_mode) begin
          mode_reg[g] <= sfr_wdata;
        end else if (wr_lo) begin
          mode_reg[g][`PCM_MODE_CMP] <= 1'b0;
        end else if (wr_hi) begin
          mode_reg[g][`PCM_MODE_CMP] <= 1'b1;
        end
      end

      // Set wins over a clear arriving in the same cycle
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          compare_event_flag[g] <= 1'b0;
        end else if (event_set[g]) begin
          compare_event_flag[g] <= 1'b1;
        end else if (flag_clear[g]) begin
          compare_event_flag[g] <= 1'b0;
        end
      end

      assign irq_en[g] = mode_reg[g][`PCM_MODE_IE];

      pcm_chan u_chan (
        .clk(clk),
        .rst(rst),
        .mode(mode_reg[g]),
        .cycle_length_sel(cycle_length_sel),
        .len_mask(len_mask),
        .wrap_evt(wrap_evt),
        .ovf16_evt(ovf16_evt),
        .main_counter(main_counter),
        .count_tick(count_tick),
        .cap_in(module_input_pin[g]),
        .wr_lo(wr_lo),
        .wr_hi(wr_hi),
        .bank(reload_bank_select),
        .wdata(sfr_wdata),
        .cmp_reg(cmp_value[g]),
        .reload_reg(reload_value[g]),
        .event_set(event_set[g]),
        .pin_reg(module_output_pin[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always @* begin
    rdata_next = `PCM_RST_BYTE;
    if (sfr_addr == `PCM_ADDR_CFG) begin
      rdata_next = cfg_read;
    end else if (mode_hit[3]) begin
      rdata_next = mode_reg[mode_hit[2:0]];
    end else if (lo_hit[3]) begin
      rdata_next = reload_bank_select ? reload_value[lo_hit[2:0]][7:0]
                                      : cmp_value[lo_hit[2:0]][7:0];
    end else if (hi_hit[3]) begin
      rdata_next = reload_bank_select ? reload_value[hi_hit[2:0]][15:8]
                                      : cmp_value[hi_hit[2:0]][15:8];
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sfr_rdata <= `PCM_RST_BYTE;
    end else if (sfr_rd) begin
      sfr_rdata <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt request
  // ----------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pca_irq <= 1'b0;
    end else begin
      pca_irq <= (cycle_wrap_flag & cycle_wrap_irq_en) |
                 (|(compare_event_flag & irq_en));
    end
  end

endmodule // pcm_top

// ---- rtl/pcm_map.vh ----
`ifndef PCM_MAP_VH
`define PCM_MAP_VH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define PCM_ADDR_CFG 8'hF7
`define PCM_ADDR_MODE6 8'hDA
`define PCM_ADDR_MODE7 8'hDB
`define PCM_ADDR_MODE8 8'hDC
`define PCM_ADDR_MODE9 8'hDD
`define PCM_ADDR_MODE10 8'hDE
`define PCM_ADDR_MODE11 8'hDF
`define PCM_ADDR_LO6 8'hFB
`define PCM_ADDR_LO7 8'hE9
`define PCM_ADDR_LO8 8'hEB
`define PCM_ADDR_LO9 8'hED
`define PCM_ADDR_LO10 8'hFD
`define PCM_ADDR_LO11 8'hCE
`define PCM_ADDR_HI6 8'hFC
`define PCM_ADDR_HI7 8'hEA
`define PCM_ADDR_HI8 8'hEC
`define PCM_ADDR_HI9 8'hEE
`define PCM_ADDR_HI10 8'hFE
`define PCM_ADDR_HI11 8'hCF

// ----------------------------------------------------------------
// Configuration register fields
// ----------------------------------------------------------------
`define PCM_CFG_BANK 7
`define PCM_CFG_WRAP_IE 6
`define PCM_CFG_WRAP_FLAG 5
`define PCM_CFG_LEN_HI 1
`define PCM_CFG_LEN_LO 0

// ----------------------------------------------------------------
// Mode register fields
// ----------------------------------------------------------------
`define PCM_MODE_WIDE 7
`define PCM_MODE_CMP 6
`define PCM_MODE_RISE 5
`define PCM_MODE_FALL 4
`define PCM_MODE_MATCH 3
`define PCM_MODE_TOG 2
`define PCM_MODE_PWM 1
`define PCM_MODE_IE 0

// ----------------------------------------------------------------
// Reset values and cycle length codes
// ----------------------------------------------------------------
`define PCM_RST_BYTE 8'h00
`define PCM_RST_WORD 16'h0000
`define PCM_LEN_8 2'h0
`define PCM_LEN_9 2'h1
`define PCM_LEN_10 2'h2
`define PCM_LEN_11 2'h3

`endif

// ---- rtl/pcm_wrap_det.v ----
`timescale 1ns/1ps
`include "pcm_map.vh"

module pcm_wrap_det (
  input wire [15:0] main_counter,
  input wire count_tick,
  input wire [1:0] cycle_length_sel,
  output wire [15:0] len_mask,
  output wire wrap_evt,
  output wire ovf16_evt
);

  // ----------------------------------------------------------------
  // Cycle length mask
  // ----------------------------------------------------------------
  function [15:0] mask_of;
    input [1:0] sel;
    begin
      case (sel)
        `PCM_LEN_8: mask_of = 16'h00FF;
        `PCM_LEN_9: mask_of = 16'h01FF;
        `PCM_LEN_10: mask_of = 16'h03FF;
        `PCM_LEN_11: mask_of = 16'h07FF;
        default: mask_of = 16'h00FF;
      endcase
    end
  endfunction

  assign len_mask = mask_of(cycle_length_sel);
  // Counter just rolled out of the selected bit
  assign wrap_evt = count_tick & ((main_counter & len_mask) == 16'h0000);
  assign ovf16_evt = count_tick & (main_counter == 16'h0000);

endmodule // pcm_wrap_det

// ---- rtl/pcm_chan.v ----
`timescale 1ns/1ps
`include "pcm_map.vh"

module pcm_chan (
  input wire clk,
  input wire rst,
  input wire [7:0] mode,
  input wire [1:0] cycle_length_sel,
  input wire [15:0] len_mask,
  input wire wrap_evt,
  input wire ovf16_evt,
  input wire [15:0] main_counter,
  input wire count_tick,
  input wire cap_in,
  input wire wr_lo,
  input wire wr_hi,
  input wire bank,
  input wire [7:0] wdata,
  output reg [15:0] cmp_reg,
  output reg [15:0] reload_reg,
  output wire event_set,
  output reg pin_reg
);

  reg cap_in_reg;
  reg [15:0] cmp_next;
  reg pin_next;
  wire wide = mode[`PCM_MODE_WIDE];
  wire pwm = mode[`PCM_MODE_PWM];
  wire tog = mode[`PCM_MODE_TOG];
  wire freq = tog & pwm;
  wire narrow_pwm = pwm & ~tog & ~wide;
  wire eq_full = main_counter == cmp_reg;
  wire eq_len = (main_counter & len_mask) == (cmp_reg & len_mask);
  wire eq_lo = main_counter[7:0] == cmp_reg[7:0];
  // 16-bit PWM ignores the cycle length field
  wire eq_sel = freq ? eq_lo : (narrow_pwm ? eq_len : eq_full);
  wire match = count_tick & mode[`PCM_MODE_CMP] & eq_sel;
  wire rise = cap_in & ~cap_in_reg;
  wire fall = ~cap_in & cap_in_reg;
  wire capture = (rise & mode[`PCM_MODE_RISE]) | (fall & mode[`PCM_MODE_FALL]);
  wire cyc_evt = wide ? ovf16_evt : wrap_evt;

  assign event_set = capture | (match & mode[`PCM_MODE_MATCH]);

  // ----------------------------------------------------------------
  // Compare value update
  // ----------------------------------------------------------------
  always @* begin
    cmp_next = cmp_reg;
    if (wr_lo & ~bank) begin
      cmp_next[7:0] = wdata;
    end else if (wr_hi & ~bank) begin
      cmp_next[15:8] = wdata;
    end else if (capture) begin
      cmp_next = main_counter;
    end else if (freq & match) begin
      cmp_next[7:0] = cmp_reg[7:0] + cmp_reg[15:8];
    end else if (narrow_pwm & wrap_evt) begin
      if (cycle_length_sel == `PCM_LEN_8) begin
        cmp_next[7:0] = cmp_reg[15:8];
      end else begin
        cmp_next = (cmp_reg & ~len_mask) | (reload_reg & len_mask);
      end
    end
  end

  // ----------------------------------------------------------------
  // Output pin
  // ----------------------------------------------------------------
  always @* begin
    pin_next = pin_reg;
    if (freq | (tog & ~pwm)) begin
      if (match) begin
        pin_next = ~pin_reg;
      end
    end else if (pwm) begin
      if (match) begin
        pin_next = 1'b0;
      end else if (cyc_evt) begin
        pin_next = 1'b1;
      end
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cap_in_reg <= 1'b0;
      cmp_reg <= `PCM_RST_WORD;
      reload_reg <= `PCM_RST_WORD;
      pin_reg <= 1'b0;
    end else begin
      cap_in_reg <= cap_in;
      cmp_reg <= cmp_next;
      pin_reg <= pin_next;
      if (wr_lo & bank) begin
        reload_reg[7:0] <= wdata;
      end
      if (wr_hi & bank) begin
        reload_reg[15:8] <= wdata;
      end
    end
  end

endmodule // pcm_chan

// ---- test/pcm_monitor.sv ----
`timescale 1ns/1ps
module pcm_monitor #(
  parameter NUM_MOD = 6
) (
  input wire clk,
  input wire rst,
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_wdata,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_rdata,
  input wire [15:0] main_counter,
  input wire count_tick,
  input wire [5:0] module_input_pin,
  input wire [5:0] flag_clear,
  input wire [5:0] compare_event_flag,
  input wire [5:0] module_output_pin,
  input wire cycle_wrap_flag,
  input wire pca_irq
);
  // ----------------------------------------------------------------
  // Shadow copies of software state
  // ----------------------------------------------------------------
  reg [7:0] m6_reg;
  reg [5:0] ie_reg;
  reg [7:0] cfg_reg;
  wire cfg_wr = sfr_wr && sfr_addr == 8'hF7;
  wire [1:0] len = cfg_reg[1:0];
  wire [15:0] mask = {5'h00, len == 2'h3, len[1], |len, 8'hFF};
  wire irq_src = (cycle_wrap_flag & cfg_reg[6]) | (|(compare_event_flag & ie_reg));
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      m6_reg <= 8'h00;
      ie_reg <= 6'h00;
      cfg_reg <= 8'h00;
    end else if (sfr_wr) begin
      if (cfg_wr) begin
        cfg_reg <= sfr_wdata;
      end
      if (sfr_addr >= 8'hDA && sfr_addr <= 8'hDF) begin
        ie_reg[sfr_addr[2:0] - 3'h2] <= sfr_wdata[0];
      end
      if (sfr_addr == 8'hDA) begin
        m6_reg <= sfr_wdata;
      end
      if (sfr_addr == 8'hFB) begin
        m6_reg[6] <= 1'b0;
      end
      if (sfr_addr == 8'hFC) begin
        m6_reg[6] <= 1'b1;
      end
    end
  end
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  cfg_read_a: assert property (
    sfr_rd && sfr_addr == 8'hF7 |=> sfr_rdata ==
      {$past(cfg_reg[7:6]), $past(cycle_wrap_flag), 3'h0, $past(cfg_reg[1:0])})
    else $error("config read mismatch");
  wrap_hold_a: assert property (
    $fell(cycle_wrap_flag) |-> $past(cfg_wr && !sfr_wdata[5]))
    else $error("wrap flag cleared without software");
  wrap_rise_a: assert property (
    $rose(cycle_wrap_flag) |-> $past(count_tick || (cfg_wr && sfr_wdata[5])))
    else $error("wrap flag set without cause");
  wrap_set_a: assert property (
    count_tick && (main_counter & mask) == 16'h0000 |=> cycle_wrap_flag)
    else $error("wrap flag missed overflow");
  irq_merge_a: assert property (
    pca_irq == $past(irq_src))
    else $error("interrupt output mismatch");
  event_hold_a: assert property (
    ($past(compare_event_flag) & ~compare_event_flag & ~$past(flag_clear)) == 6'h00)
    else $error("event flag cleared by hardware");
  mode_read_a: assert property (
    sfr_rd && sfr_addr == 8'hDA |=> sfr_rdata == $past(m6_reg))
    else $error("mode register read mismatch");
  pin_cause_a: assert property (
    module_output_pin != $past(module_output_pin) |-> $past(count_tick))
    else $error("output pin moved without tick");
endmodule // pcm_monitor

bind pcm_top pcm_monitor #(.NUM_MOD(NUM_MOD)) pcm_monitor_inst (.clk(clk), .rst(rst),
  .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
  .sfr_rdata(sfr_rdata), .main_counter(main_counter), .count_tick(count_tick),
  .module_input_pin(module_input_pin), .flag_clear(flag_clear),
  .compare_event_flag(compare_event_flag), .module_output_pin(module_output_pin),
  .cycle_wrap_flag(cycle_wrap_flag), .pca_irq(pca_irq));

// ---- test/pcm_top_tb.sv ----
`timescale 1ns/1ps
`include "pcm_map.vh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin errors++; \
  $display("mismatch %s expected %0h seen %0h", n, e, g); end end
module pcm_top_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [15:0] main_counter = 16'h0000;
  logic count_tick = 1'b0;
  logic [5:0] module_input_pin = 6'h00;
  logic [5:0] flag_clear = 6'h00;
  wire [7:0] sfr_rdata;
  wire [5:0] compare_event_flag;
  wire [5:0] module_output_pin;
  wire cycle_wrap_flag;
  wire pca_irq;
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;
  always #12.5 clk = ~clk;
  pcm_top #(.NUM_MOD(6)) pcm_top_inst (.clk(clk), .rst(rst), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .main_counter(main_counter), .count_tick(count_tick),
    .module_input_pin(module_input_pin), .flag_clear(flag_clear),
    .compare_event_flag(compare_event_flag), .module_output_pin(module_output_pin),
    .cycle_wrap_flag(cycle_wrap_flag), .pca_irq(pca_irq));
  // ----------------------------------------------------------------
  // Bus and event helpers
  // ----------------------------------------------------------------
  task automatic wr(input [7:0] a, input [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask
  task automatic rchk(input [7:0] a, input [7:0] e);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    `CHK("sfr_rdata", e, sfr_rdata);
  endtask
  task automatic tick(input [15:0] c);
    @(negedge clk);
    main_counter = c;
    count_tick = 1'b1;
    @(negedge clk);
    count_tick = 1'b0;
  endtask
  task automatic clr(input [5:0] m);
    @(negedge clk);
    flag_clear = m;
    @(negedge clk);
    flag_clear = 6'h00;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    logic [7:0] i;
    for (i = 0; i < 6; i++) rchk(8'hDA + i, 8'h00);
    rchk(`PCM_ADDR_CFG, 8'h00);
    rchk(8'h80, 8'h00);
    $display("reset test done");
  endtask
  task automatic t_wrap;
    logic [7:0] i;
    wr(`PCM_ADDR_CFG, 8'hFC);
    rchk(`PCM_ADDR_CFG, 8'hE0);
    `CHK("pca_irq", 1'b1, pca_irq);
    for (i = 0; i < 4; i++) begin
      wr(`PCM_ADDR_CFG, i);
      `CHK("wrap_flag", 1'b0, cycle_wrap_flag);
      tick(16'h0001 << (7 + i));
      `CHK("wrap_flag", 1'b0, cycle_wrap_flag);
      tick(16'h0001 << (8 + i));
      `CHK("wrap_flag", 1'b1, cycle_wrap_flag);
      tick(16'h0003);
      `CHK("wrap_flag", 1'b1, cycle_wrap_flag);
      `CHK("pca_irq", 1'b0, pca_irq);
    end
    wr(`PCM_ADDR_CFG, 8'h00);
    $display("wrap test done");
  endtask
  task automatic t_mode;
    logic [7:0] i;
    for (i = 0; i < 6; i++) begin
      wr(8'hDA + i, 8'hA5 ^ i);
      rchk(8'hDA + i, 8'hA5 ^ i);
    end
    wr(`PCM_ADDR_HI6, 8'h00);
    rchk(`PCM_ADDR_MODE6, 8'hE5);
    wr(`PCM_ADDR_LO6, 8'h00);
    rchk(`PCM_ADDR_MODE6, 8'hA5);
    for (i = 0; i < 6; i++) wr(8'hDA + i, 8'h00);
    $display("mode test done");
  endtask
  task automatic t_bank;
    wr(`PCM_ADDR_LO7, 8'h34);
    wr(`PCM_ADDR_HI7, 8'h12);
    wr(`PCM_ADDR_CFG, 8'h80);
    wr(`PCM_ADDR_LO7, 8'hCD);
    wr(`PCM_ADDR_HI7, 8'hAB);
    rchk(`PCM_ADDR_LO7, 8'hCD);
    rchk(`PCM_ADDR_HI7, 8'hAB);
    wr(`PCM_ADDR_CFG, 8'h00);
    rchk(`PCM_ADDR_LO7, 8'h34);
    rchk(`PCM_ADDR_HI7, 8'h12);
    rchk(`PCM_ADDR_MODE7, 8'h40);
    wr(`PCM_ADDR_MODE7, 8'h00);
    $display("bank test done");
  endtask
  task automatic t_match;
    wr(`PCM_ADDR_LO6, 8'h55);
    wr(`PCM_ADDR_HI6, 8'h00);
    wr(`PCM_ADDR_MODE6, 8'h4D);
    tick(16'h0055);
    `CHK("event_flag", 6'h01, compare_event_flag);
    `CHK("out_pin", 1'b1, module_output_pin[0]);
    @(negedge clk);
    `CHK("pca_irq", 1'b1, pca_irq);
    clr(6'h01);
    `CHK("event_flag", 6'h00, compare_event_flag);
    wr(`PCM_ADDR_MODE6, 8'h0D);
    tick(16'h0055);
    `CHK("event_flag", 6'h00, compare_event_flag);
    `CHK("out_pin", 1'b1, module_output_pin[0]);
    wr(`PCM_ADDR_MODE6, 8'h00);
    $display("match test done");
  endtask
  task automatic t_cap;
    wr(`PCM_ADDR_MODE8, 8'h20);
    @(negedge clk);
    main_counter = 16'h0321;
    module_input_pin = 6'h04;
    repeat (3) @(negedge clk);
    rchk(`PCM_ADDR_LO8, 8'h21);
    rchk(`PCM_ADDR_HI8, 8'h03);
    `CHK("event_flag", 1'b1, compare_event_flag[2]);
    clr(6'h04);
    wr(`PCM_ADDR_MODE8, 8'h10);
    @(negedge clk);
    main_counter = 16'h0456;
    module_input_pin = 6'h00;
    repeat (3) @(negedge clk);
    rchk(`PCM_ADDR_LO8, 8'h56);
    rchk(`PCM_ADDR_HI8, 8'h04);
    `CHK("event_flag", 1'b1, compare_event_flag[2]);
    clr(6'h04);
    wr(`PCM_ADDR_MODE8, 8'h00);
    $display("capture test done");
  endtask
  task automatic t_pwm;
    wr(`PCM_ADDR_LO10, 8'h40);
    wr(`PCM_ADDR_HI10, 8'h40);
    wr(`PCM_ADDR_MODE10, 8'h42);
    tick(16'h0100);
    `CHK("out_pin", 1'b1, module_output_pin[4]);
    tick(16'h0140);
    `CHK("out_pin", 1'b0, module_output_pin[4]);
    wr(`PCM_ADDR_LO11, 8'h34);
    wr(`PCM_ADDR_HI11, 8'h12);
    wr(`PCM_ADDR_MODE11, 8'hC2);
    wr(`PCM_ADDR_CFG, 8'h03);
    tick(16'h0000);
    `CHK("out_pin", 1'b1, module_output_pin[5]);
    tick(16'h0234);
    `CHK("out_pin", 1'b1, module_output_pin[5]);
    tick(16'h1234);
    `CHK("out_pin", 1'b0, module_output_pin[5]);
    tick(16'h0800);
    `CHK("out_pin", 1'b0, module_output_pin[5]);
    wr(`PCM_ADDR_MODE10, 8'h00);
    wr(`PCM_ADDR_MODE11, 8'h00);
    wr(`PCM_ADDR_CFG, 8'h00);
    $display("pwm test done");
  endtask
  task automatic t_reload;
    wr(`PCM_ADDR_CFG, 8'h80);
    wr(`PCM_ADDR_LO9, 8'h80);
    wr(`PCM_ADDR_HI9, 8'h01);
    wr(`PCM_ADDR_CFG, 8'h01);
    wr(`PCM_ADDR_LO9, 8'h10);
    wr(`PCM_ADDR_HI9, 8'h00);
    wr(`PCM_ADDR_MODE9, 8'h42);
    tick(16'h0200);
    `CHK("out_pin", 1'b1, module_output_pin[3]);
    rchk(`PCM_ADDR_LO9, 8'h80);
    rchk(`PCM_ADDR_HI9, 8'h01);
    wr(`PCM_ADDR_CFG, 8'h00);
    tick(16'h0300);
    rchk(`PCM_ADDR_LO9, 8'h01);
    wr(`PCM_ADDR_MODE9, 8'h00);
    wr(`PCM_ADDR_LO6, 8'h10);
    wr(`PCM_ADDR_HI6, 8'h08);
    wr(`PCM_ADDR_MODE6, 8'h46);
    tick(16'h0010);
    `CHK("out_pin", 1'b0, module_output_pin[0]);
    rchk(`PCM_ADDR_LO6, 8'h18);
    tick(16'h0018);
    `CHK("out_pin", 1'b1, module_output_pin[0]);
    wr(`PCM_ADDR_MODE6, 8'h00);
    $display("reload and frequency test done");
  endtask
  // ----------------------------------------------------------------
  // Sequence and verdict
  // ----------------------------------------------------------------
  task tally_and_finish;
    $display("tests_run %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_reset;
    t_wrap;
    t_mode;
    t_bank;
    t_match;
    t_cap;
    t_pwm;
    t_reload;
    tally_and_finish;
  end
endmodule // pcm_top_tb
